// >>> design/idq_pkg.sv
// Purpose: Shared constants for the isolated input conditioning block.
// Assumes: A single 125 MHz clock named mclk.
// Notes: Register offsets are word indices on the plain register port.
package idq_pkg;
  // Clock rate and the one-microsecond tick.
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int TICK_W = 7;
  localparam logic [TICK_W-1:0] TICK_LAST = 7'(TICK_CYCLES - 1);
  // Debounce setting.
  localparam int DEB_W = 8;
  localparam logic [7:0] DEB_MIN = 8'h01;
  localparam logic [7:0] DEB_RST = 8'h00;
  localparam int NUM_IN = 2;
  // Register addresses.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DEB0 = 4'h1;
  localparam logic [3:0] REG_DEB1 = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_TCNT0 = 4'h4;
  localparam logic [3:0] REG_TCNT1 = 4'h5;
  // Control field positions.
  localparam int CTL_MODE0 = 0;
  localparam int CTL_MODE1 = 1;
  localparam int CTL_STD0 = 4;
  localparam int CTL_STD1 = 6;
  localparam int CTL_STOP_EN = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] CTRL_MASK = 32'h0000_01F3;
  // Status field positions.
  localparam int ST_LVL0 = 0;
  localparam int ST_LVL1 = 1;
  localparam int ST_SUP = 2;
  localparam int ST_LASER = 3;
  // Switching standards.
  typedef enum logic [1:0] {
    IDQ_STD_RS422 = 2'h0,
    IDQ_STD_TTL = 2'h1,
    IDQ_STD_12V = 2'h2,
    IDQ_STD_24V = 2'h3
  } idq_std_t;
endpackage

// >>> design/idq_sync.sv
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: Input may be asynchronous to mclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module idq_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1_ff;
    logic s2_ff;
  } idq_sync_st_t;
  idq_sync_st_t st_ff, nxt_st;

  // Shift the level through two stages.
  always_comb begin
    nxt_st.s1_ff = din;
    nxt_st.s2_ff = st_ff.s1_ff;
  end

  // Register the state.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2_ff;
endmodule // idq_sync

// >>> design/idq_deb.sv
// Purpose: Debounce filter for one synchronised input.
// Assumes: A one-cycle tick every microsecond.
// Notes: A level is accepted once it has held past the set count of ticks.
`timescale 1ns/10ps
module idq_deb (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic lvl,
  input wire logic [7:0] deb_set,
  output logic clean,
  output logic rise
);
  typedef struct packed {
    logic prev_ff;
    logic clean_ff;
    logic rise_ff;
    logic [7:0] cnt_ff;
  } idq_deb_st_t;
  idq_deb_st_t st_ff, nxt_st;
  logic [7:0] limit;

  // Zero acts as the shortest setting.
  assign limit = (deb_set == 8'h00) ? idq_pkg::DEB_MIN : deb_set;

  // Restart on every raw change; accept at tick number limit plus one.
  // The first tick may come one cycle after a change, so accepting at tick number limit
  // would pass a pulse almost a microsecond shorter than the setting.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev_ff = lvl;
    nxt_st.rise_ff = 1'b0;
    if (lvl != st_ff.prev_ff) begin
      nxt_st.cnt_ff = 8'h00;
    end else if (lvl == st_ff.clean_ff) begin
      nxt_st.cnt_ff = 8'h00;
    end else if (tick) begin
      if (st_ff.cnt_ff >= limit) begin
        nxt_st.clean_ff = lvl;
        nxt_st.rise_ff = lvl;
        nxt_st.cnt_ff = 8'h00;
      end else begin
        nxt_st.cnt_ff = st_ff.cnt_ff + 8'h01;
      end
    end
  end

  // Register the state.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clean = st_ff.clean_ff;
  assign rise = st_ff.rise_ff;

  // A changed level never passes before one full tick has been seen.
  a_deb_no_glitch: assert property (@(posedge mclk) disable iff (!nrst)
    (st_ff.clean_ff != $past(st_ff.clean_ff)) |-> $past(tick))
    else $error("Debounced level changed without a tick.");
endmodule // idq_deb

// >>> design/idq_top.sv
// Purpose: Conditions two isolated inputs and gates the laser on the stop supply.
// Assumes: Register port is synchronous to mclk; pins are synchronised here.
// Notes: Trigger pulses are one cycle long after a debounced rising edge.
`timescale 1ns/10ps
module idq_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic iso_input_one,
  input wire logic iso_input_two,
  input wire logic laser_stop_supply,
  input wire logic laser_request,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [1:0] trig_pulse,
  output logic [1:0] gp_level,
  output logic [1:0] thr_sel_one,
  output logic [1:0] thr_sel_two,
  output logic laser_enable
);
  typedef struct packed {
    logic [31:0] ctrl_ff;
    logic [7:0] deb0_ff;
    logic [7:0] deb1_ff;
    logic [15:0] tcnt0_ff;
    logic [15:0] tcnt1_ff;
    logic [31:0] rdata_ff;
    logic [6:0] tick_cnt_ff;
    logic tick_ff;
    logic [1:0] trig_ff;
    logic laser_ff;
  } idq_top_st_t;
  idq_top_st_t st_ff, nxt_st;

  logic [1:0] raw_in;
  logic [1:0] sync_in;
  logic [1:0] clean;
  logic [1:0] rise;
  logic sup_sync;
  logic [7:0] deb_set [2];

  // Register read decode, used for the read data path.
  function automatic logic [31:0] rd_mux(input logic [3:0] a, input idq_top_st_t s,
      input logic [1:0] lv, input logic sp);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      idq_pkg::REG_CTRL: r = s.ctrl_ff;
      idq_pkg::REG_DEB0: r = {24'h00_0000, s.deb0_ff};
      idq_pkg::REG_DEB1: r = {24'h00_0000, s.deb1_ff};
      idq_pkg::REG_STAT: r = {28'h000_0000, s.laser_ff, sp, lv};
      idq_pkg::REG_TCNT0: r = {16'h0000, s.tcnt0_ff};
      idq_pkg::REG_TCNT1: r = {16'h0000, s.tcnt1_ff};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign raw_in = {iso_input_two, iso_input_one};
  assign deb_set[0] = st_ff.deb0_ff;
  assign deb_set[1] = st_ff.deb1_ff;

  // Each input is synchronised then debounced on its own setting.
  generate
    for (genvar i = 0; i < idq_pkg::NUM_IN; i++) begin : g_in
      idq_sync u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(raw_in[i]),
        .dout(sync_in[i])
      );
      idq_deb u_deb (
        .mclk(mclk),
        .nrst(nrst),
        .tick(st_ff.tick_ff),
        .lvl(sync_in[i]),
        .deb_set(deb_set[i]),
        .clean(clean[i]),
        .rise(rise[i])
      );
    end
  endgenerate

  // The stop supply is a level from a separate circuit, so it is synchronised too.
  idq_sync u_sup (
    .mclk(mclk),
    .nrst(nrst),
    .din(laser_stop_supply),
    .dout(sup_sync)
  );

  // Next state: tick, registers, triggers and the laser gate.
  always_comb begin
    nxt_st = st_ff;
    // Microsecond tick from the 125 MHz clock.
    if (st_ff.tick_cnt_ff == idq_pkg::TICK_LAST) begin
      nxt_st.tick_cnt_ff = 7'h00;
      nxt_st.tick_ff = 1'b1;
    end else begin
      nxt_st.tick_cnt_ff = st_ff.tick_cnt_ff + 7'h01;
      nxt_st.tick_ff = 1'b0;
    end
    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        idq_pkg::REG_CTRL: nxt_st.ctrl_ff = reg_wdata & idq_pkg::CTRL_MASK;
        idq_pkg::REG_DEB0: nxt_st.deb0_ff = reg_wdata[7:0];
        idq_pkg::REG_DEB1: nxt_st.deb1_ff = reg_wdata[7:0];
        idq_pkg::REG_TCNT0: nxt_st.tcnt0_ff = 16'h0000;
        idq_pkg::REG_TCNT1: nxt_st.tcnt1_ff = 16'h0000;
        default: nxt_st.ctrl_ff = st_ff.ctrl_ff;
      endcase
    end
    // Triggers only from inputs set to trigger mode; counting wins over a clear.
    nxt_st.trig_ff[0] = rise[0] & st_ff.ctrl_ff[idq_pkg::CTL_MODE0];
    nxt_st.trig_ff[1] = rise[1] & st_ff.ctrl_ff[idq_pkg::CTL_MODE1];
    if (nxt_st.trig_ff[0]) begin
      nxt_st.tcnt0_ff = ((reg_wr && reg_addr == idq_pkg::REG_TCNT0) ? 16'h0000 :
          st_ff.tcnt0_ff) + 16'h0001;
    end
    if (nxt_st.trig_ff[1]) begin
      nxt_st.tcnt1_ff = ((reg_wr && reg_addr == idq_pkg::REG_TCNT1) ? 16'h0000 :
          st_ff.tcnt1_ff) + 16'h0001;
    end
    // Laser gate: supply required while the interlock is enabled.
    nxt_st.laser_ff = laser_request &
        (sup_sync | ~st_ff.ctrl_ff[idq_pkg::CTL_STOP_EN]);
    // Read data stands one cycle after the strobe.
    nxt_st.rdata_ff = reg_rd ? rd_mux(reg_addr, st_ff, clean, sup_sync) : 32'h0000_0000;
  end

  // Register the state; interlock enabled at reset.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.ctrl_ff <= idq_pkg::CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata_ff;
  assign trig_pulse = st_ff.trig_ff;
  assign gp_level = clean;
  // Threshold selects drive the analog comparator references.
  assign thr_sel_one = st_ff.ctrl_ff[idq_pkg::CTL_STD0 +: 2];
  assign thr_sel_two = st_ff.ctrl_ff[idq_pkg::CTL_STD1 +: 2];
  assign laser_enable = st_ff.laser_ff;

  // Sequence for the trigger path.
  sequence s_rise0;
    rise[0] && st_ff.ctrl_ff[idq_pkg::CTL_MODE0];
  endsequence

  a_laser_gate_off: assert property (@(posedge mclk) disable iff (!nrst)
    (st_ff.ctrl_ff[idq_pkg::CTL_STOP_EN] && !sup_sync) |=> !laser_enable)
    else $error("Laser enabled without stop supply.");

  a_laser_bypass: assert property (@(posedge mclk) disable iff (!nrst)
    (!st_ff.ctrl_ff[idq_pkg::CTL_STOP_EN] && laser_request) |=> laser_enable)
    else $error("Laser held off with interlock disabled.");

  a_trig_fires: assert property (@(posedge mclk) disable iff (!nrst)
    s_rise0 |=> trig_pulse[0])
    else $error("Trigger not issued after debounced rise.");

  a_trig_mode_gp: assert property (@(posedge mclk) disable iff (!nrst)
    trig_pulse[1] |-> $past(st_ff.ctrl_ff[idq_pkg::CTL_MODE1]))
    else $error("Trigger from plain input.");

  a_tick_period: assert property (@(posedge mclk) disable iff (!nrst)
    st_ff.tick_ff |=> !st_ff.tick_ff [*8])
    else $error("Tick spacing too short.");

  a_trig_pulse_one: assert property (@(posedge mclk) disable iff (!nrst)
    trig_pulse[0] |=> !trig_pulse[0])
    else $error("Trigger pulse longer than one cycle.");

  a_deb_reg_wr: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == idq_pkg::REG_DEB0) |=> st_ff.deb0_ff == $past(reg_wdata[7:0]))
    else $error("Debounce setting not stored.");

  a_thr_follow: assert property (@(posedge mclk) disable iff (!nrst)
    (reg_wr && reg_addr == idq_pkg::REG_CTRL) |=> thr_sel_two == $past(reg_wdata[7:6]))
    else $error("Threshold select not updated.");
endmodule // idq_top

// >>> bench/idq_field_src.sv
// Purpose: Field equipment model driving the two isolated inputs and the stop supply.
// Assumes: Levels change by non-blocking assignment right after a rising edge of mclk.
// Notes: Spans are whole microseconds of 125 cycles each.
`timescale 1ns/10ps
module idq_field_src (
  input wire logic mclk,
  output logic [1:0] lvl,
  output logic supply
);
  // Inputs idle low and the stop supply starts absent.
  initial begin
    lvl = 2'h0;
    supply = 1'b0;
  end
  // Waits a number of microseconds.
  task automatic wait_us(input int us);
    repeat (us * idq_pkg::TICK_CYCLES) @(posedge mclk);
  endtask
  // Raises one input for a span, then rests low so the toggle rate stays slow.
  task automatic pulse(input int idx, input int us);
    @(posedge mclk);
    lvl[idx] <= 1'b1;
    wait_us(us);
    lvl[idx] <= 1'b0;
    wait_us(10);
  endtask
  // Sets a steady level as a plain switch would, then keeps it long enough.
  task automatic hold(input int idx, input logic v);
    @(posedge mclk);
    lvl[idx] <= v;
    wait_us(10);
  endtask
  // Applies or removes the stop supply.
  task automatic set_supply(input logic v);
    @(posedge mclk);
    supply <= v;
  endtask
endmodule // idq_field_src

// >>> bench/idq_top_bench.sv
// Purpose: Self-checking bench for the isolated input conditioning block.
// Assumes: Expected results are queued by the driver and compared when they appear.
// Notes: Short debounce settings keep the run to about 11250 cycles.
`timescale 1ns/10ps
module idq_top_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic laser_request = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic probe = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] trig_pulse, gp_level, thr_sel_one, thr_sel_two, lvl;
  logic laser_enable, supply;
  logic [31:0] expq[$];
  logic [15:0] seed = 16'h1F51; // Decimal 8017.
  logic [3:0] tseen0 = 4'h0;
  logic [3:0] tseen1 = 4'h0;
  int failures = 0;
  int samples_checked = 0;

  // Clock of 8 ns.
  always #4 mclk = ~mclk;

  idq_field_src src (.mclk(mclk), .lvl(lvl), .supply(supply));
  idq_top dut (.mclk(mclk), .nrst(nrst), .iso_input_one(lvl[0]), .iso_input_two(lvl[1]),
    .laser_stop_supply(supply), .laser_request(laser_request), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_pulse(trig_pulse), .gp_level(gp_level), .thr_sel_one(thr_sel_one),
    .thr_sel_two(thr_sel_two), .laser_enable(laser_enable));

  // Pseudo-random sequence for the second input's standard.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Compares one result and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; the data is compared by the monitor a cycle later.
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // Asks the monitor to sample the laser gate, trigger counts, selections and levels.
  task automatic look(input logic [31:0] e);
    expq.push_back(e);
    @(posedge mclk);
    probe <= 1'b1;
    @(posedge mclk);
    probe <= 1'b0;
  endtask

  // Monitor: read data stands only in the cycle after the strobe, so it is taken there.
  always @(posedge mclk) begin
    if (rd_seen || probe) begin
      check(rd_seen ? reg_rdata :
        {17'h0, laser_enable, tseen1, tseen0, thr_sel_two, thr_sel_one, gp_level},
        expq.pop_front());
    end
    rd_seen <= reg_rd;
    // Counting high cycles, not edges, catches a trigger pulse that lasts too long.
    tseen0 <= tseen0 + {3'h0, trig_pulse[0]};
    tseen1 <= tseen1 + {3'h0, trig_pulse[1]};
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rd(idq_pkg::REG_CTRL, idq_pkg::CTRL_RST);
    rd(4'h7, 32'h0);
    rd(idq_pkg::REG_STAT, 32'h0);
    wr(idq_pkg::REG_CTRL, 32'h0000_0103);
    wr(idq_pkg::REG_STAT, 32'hFFFF_FFFF);
    rd(idq_pkg::REG_CTRL, 32'h0000_0103);
    wr(idq_pkg::REG_DEB0, 32'h0);
    wr(idq_pkg::REG_DEB1, 32'h5);
    rd(idq_pkg::REG_DEB0, 32'h0);
    rd(idq_pkg::REG_DEB1, 32'h5);
    src.pulse(0, 3);
    rd(idq_pkg::REG_TCNT0, 32'h1);
    src.pulse(0, 1);
    rd(idq_pkg::REG_TCNT0, 32'h1);
    wr(idq_pkg::REG_TCNT0, 32'h0);
    rd(idq_pkg::REG_TCNT0, 32'h0);
    src.pulse(1, 3);
    src.pulse(1, 5);
    rd(idq_pkg::REG_TCNT1, 32'h0);
    src.pulse(1, 7);
    rd(idq_pkg::REG_TCNT1, 32'h1);
    wr(idq_pkg::REG_CTRL, 32'h0000_0101);
    wr(idq_pkg::REG_TCNT1, 32'h0);
    src.hold(1, 1'b1);
    rd(idq_pkg::REG_STAT, 32'h2);
    rd(idq_pkg::REG_TCNT1, 32'h0);
    src.hold(1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(idq_pkg::REG_CTRL, {23'h0, 1'b1, seed[1:0], i[1:0], 4'h0});
      repeat (2) @(posedge mclk);
      look({17'h0, 1'b0, 4'h1, 4'h1, seed[1:0], i[1:0], 2'h0});
    end
    laser_request <= 1'b1;
    rd(idq_pkg::REG_STAT, 32'h0);
    src.set_supply(1'b1);
    repeat (5) @(posedge mclk);
    rd(idq_pkg::REG_STAT, 32'hC);
    src.set_supply(1'b0);
    repeat (5) @(posedge mclk);
    rd(idq_pkg::REG_STAT, 32'h0);
    wr(idq_pkg::REG_CTRL, 32'h0);
    repeat (5) @(posedge mclk);
    rd(idq_pkg::REG_STAT, 32'h8);
    look({17'h0, 1'b1, 4'h1, 4'h1, 6'h00});
    summarize();
  end

  // Watchdog: the tests need about 11250 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    summarize();
  end
endmodule // idq_top_bench
